// ==== include/dtp_pkg.sv ====
// Constants shared by the dual timer with demodulation and ping-pong
package dtp_pkg;

  // ==========================================================
  // Control bit positions
  localparam int EN_BIT = 7;
  localparam int SINGLE_BIT = 6;
  localparam int STATUS_BIT = 5;
  localparam int CAP_IRQ_BIT = 2;
  localparam int TC_IRQ_BIT = 1;
  localparam int MODE_BIT = 6;
  localparam int EDGE_HI = 5;
  localparam int EDGE_LO = 4;
  localparam int PP_HI = 3;
  localparam int PP_LO = 2;
  localparam int INIT8_BIT = 1;
  localparam int INIT16_BIT = 0;

  // ==========================================================
  // Field codes
  localparam logic [1:0] PP_CODE = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [3:0] TIMER_BANK = 4'hd;
  localparam int RP_GROUP_HI = 7;
  localparam int RP_GROUP_LO = 4;
  localparam int RP_BANK_HI = 3;
  localparam int RP_BANK_LO = 0;
  localparam logic [15:0] WRAP_VALUE = 16'hffff;

  // ==========================================================
  // Ping-pong sequencer states
  typedef enum logic [1:0] {PP_IDLE, PP_T8, PP_T16} dtp_pp_state_t;

endpackage

// ==== rtl/dtp_down_counter.sv ====
// Loadable down counter used by both timers
`timescale 1ns/100ps
`default_nettype none

module dtp_down_counter #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  input wire logic i_dec,
  output logic [WIDTH-1:0] o_count,
  output logic o_zero
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // ==========================================================
  // Load beats decrement; zero wraps to all ones
  always_comb begin
    count_next = count_reg;
    if (i_load) begin
      count_next = i_load_value;
    end else if (i_dec) begin
      count_next = count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;
  assign o_zero = (count_reg == '0);

endmodule

`default_nettype wire

// ==== rtl/dtp_timer.sv ====
// Paired 8-bit and 16-bit timers with demodulation and ping-pong
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Armed single-edge mode ignores later edges
// - Timer8 timeout in single-edge mode captures timer16 without reload
// - Rewriting bit six rearms one capture-reload edge
// - In demodulation, timer16 wraps to all ones, flags timeout
// - Ping-pong only runs in transmit mode
// - Timer8 starts at initial level, loads hold
// - Timer8 end hands over to timer16
// - Timer16 end hands back to timer8
// - Terminal count interrupts gated by enable bits
// - Ping-pong select of zero ends alternation
// - Pointer high nibble group, low nibble bank
// - Timer registers live in bank D
module dtp_timer (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_register_pointer,
  input wire logic [7:0] i_timer8_control,
  input wire logic [7:0] i_common_timer_control,
  input wire logic [7:0] i_timer16_control,
  input wire logic [7:0] i_timer8_high_hold,
  input wire logic [7:0] i_timer8_low_hold,
  input wire logic [7:0] i_timer16_high_hold,
  input wire logic [7:0] i_timer16_low_hold,
  input wire logic i_timer16_status_clear,
  input wire logic i_demod_pin,
  output logic [3:0] o_working_group,
  output logic [3:0] o_erf_bank,
  output logic o_timer_bank_sel,
  output logic o_timer8_output,
  output logic o_timer16_output,
  output logic [15:0] o_timer16_capture,
  output logic o_timer16_status,
  output logic o_timer8_irq,
  output logic o_timer16_irq
);

  dtp_pkg::dtp_pp_state_t pp_state_reg, pp_state_next;
  logic pin_s1_reg, pin_s1_next, pin_s2_reg, pin_s2_next, pin_s3_reg, pin_s3_next;
  logic out8_reg, out8_next, out16_reg, out16_next;
  logic run8_reg, run8_next, run16_reg, run16_next;
  logic armed_reg, armed_next, status_reg, status_next;
  logic irq8_reg, irq8_next, irq16_reg, irq16_next;
  logic en8_d_reg, en8_d_next, en16_d_reg, en16_d_next;
  logic sgl16_d_reg, sgl16_d_next, demod_d_reg, demod_d_next;
  logic [15:0] cap_reg, cap_next;
  logic load8, load16, zero8, zero16, tc8, tc16;
  logic [7:0] val8, count8;
  logic [15:0] count16;
  logic demod, pp_sel, en8, en16, rise8, rise16, sgl16, rearm, edge_seen, edge_load;
  logic [1:0] edge_sel;

  // ==========================================================
  // Register pointer decode
  assign o_working_group = i_register_pointer[dtp_pkg::RP_GROUP_HI:dtp_pkg::RP_GROUP_LO];
  assign o_erf_bank = i_register_pointer[dtp_pkg::RP_BANK_HI:dtp_pkg::RP_BANK_LO];
  assign o_timer_bank_sel = (o_erf_bank == dtp_pkg::TIMER_BANK);

  // ==========================================================
  // Control decode
  assign demod = i_common_timer_control[dtp_pkg::MODE_BIT];
  assign pp_sel = (i_common_timer_control[dtp_pkg::PP_HI:dtp_pkg::PP_LO] == dtp_pkg::PP_CODE);
  assign edge_sel = i_common_timer_control[dtp_pkg::EDGE_HI:dtp_pkg::EDGE_LO];
  assign en8 = i_timer8_control[dtp_pkg::EN_BIT];
  assign en16 = i_timer16_control[dtp_pkg::EN_BIT];
  assign sgl16 = i_timer16_control[dtp_pkg::SINGLE_BIT];
  assign rise8 = en8 && !en8_d_reg;
  assign rise16 = en16 && !en16_d_reg;
  assign rearm = demod && ((sgl16 && !sgl16_d_reg) || !demod_d_reg);
  assign tc8 = run8_reg && zero8;
  assign tc16 = run16_reg && zero16;
  // Edge detect reads only the second and third stages
  assign edge_seen = ((edge_sel == dtp_pkg::EDGE_RISE) && pin_s2_reg && !pin_s3_reg)
                  || ((edge_sel == dtp_pkg::EDGE_FALL) && !pin_s2_reg && pin_s3_reg)
                  || ((edge_sel == dtp_pkg::EDGE_BOTH) && (pin_s2_reg != pin_s3_reg));
  assign edge_load = demod && run16_reg && edge_seen && (!sgl16 || armed_reg);

  // ==========================================================
  // Next-state logic
  always_comb begin
    pp_state_next = pp_state_reg;
    pin_s1_next = i_demod_pin;
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
    out8_next = out8_reg;
    out16_next = out16_reg;
    run8_next = run8_reg;
    run16_next = run16_reg;
    armed_next = armed_reg;
    status_next = status_reg;
    cap_next = cap_reg;
    irq8_next = 1'b0;
    irq16_next = 1'b0;
    en8_d_next = en8;
    en16_d_next = en16;
    sgl16_d_next = sgl16;
    demod_d_next = demod;
    load8 = 1'b0;
    load16 = 1'b0;
    if (demod) begin
      pp_state_next = dtp_pkg::PP_IDLE;
      run8_next = en8;
      run16_next = en16;
      load8 = rise8 || tc8;
      if (edge_load) begin
        cap_next = count16;
        load16 = 1'b1;
        armed_next = 1'b0;
      end else if (sgl16 && tc8) begin
        cap_next = count16;
        irq16_next = i_timer16_control[dtp_pkg::CAP_IRQ_BIT];
      end else if (rise16) begin
        // Load on enable, else a fresh start wraps at once from zero
        load16 = 1'b1;
      end
      if (tc16 && !edge_load) begin
        status_next = 1'b1;
        irq16_next = i_timer16_control[dtp_pkg::TC_IRQ_BIT];
      end
      if (rearm) begin
        armed_next = 1'b1;
      end
    end else if (pp_sel) begin
      // Pulses below are one clock wide by construction
      case (pp_state_reg)
        dtp_pkg::PP_IDLE: begin
          run8_next = 1'b0;
          run16_next = 1'b0;
          if (rise8) begin
            pp_state_next = dtp_pkg::PP_T8;
            out8_next = i_common_timer_control[dtp_pkg::INIT8_BIT];
            load8 = 1'b1;
            run8_next = 1'b1;
          end else if (rise16) begin
            pp_state_next = dtp_pkg::PP_T16;
            out16_next = i_common_timer_control[dtp_pkg::INIT16_BIT];
            load16 = 1'b1;
            run16_next = 1'b1;
          end
        end
        dtp_pkg::PP_T8: begin
          if (tc8) begin
            irq8_next = i_timer8_control[dtp_pkg::TC_IRQ_BIT];
            pp_state_next = dtp_pkg::PP_T16;
            run8_next = 1'b0;
            out16_next = i_common_timer_control[dtp_pkg::INIT16_BIT];
            load16 = 1'b1;
            run16_next = 1'b1;
          end
        end
        default: begin
          if (tc16) begin
            irq16_next = i_timer16_control[dtp_pkg::TC_IRQ_BIT];
            pp_state_next = dtp_pkg::PP_T8;
            run16_next = 1'b0;
            out8_next = i_common_timer_control[dtp_pkg::INIT8_BIT];
            load8 = 1'b1;
            run8_next = 1'b1;
          end
        end
      endcase
    end else begin
      // Ping-pong deselected: alternation ends here
      pp_state_next = dtp_pkg::PP_IDLE;
      if (!en8) begin
        run8_next = 1'b0;
      end else if (rise8) begin
        out8_next = i_common_timer_control[dtp_pkg::INIT8_BIT];
        run8_next = 1'b1;
        load8 = 1'b1;
      end else if (tc8) begin
        out8_next = !out8_reg;
        irq8_next = i_timer8_control[dtp_pkg::TC_IRQ_BIT];
        run8_next = !i_timer8_control[dtp_pkg::SINGLE_BIT];
        load8 = run8_next;
      end
      if (!en16) begin
        run16_next = 1'b0;
      end else if (rise16) begin
        out16_next = i_common_timer_control[dtp_pkg::INIT16_BIT];
        run16_next = 1'b1;
        load16 = 1'b1;
      end else if (tc16) begin
        out16_next = !out16_reg;
        irq16_next = i_timer16_control[dtp_pkg::TC_IRQ_BIT];
        run16_next = !sgl16;
        load16 = run16_next;
      end
    end
    // Hardware set wins over a same-cycle software clear
    if (i_timer16_status_clear && !(demod && tc16 && !edge_load)) begin
      status_next = 1'b0;
    end
    // Demodulation reloads timer8 from its low hold only
    val8 = (out8_next && !demod) ? i_timer8_high_hold : i_timer8_low_hold;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pp_state_reg <= dtp_pkg::PP_IDLE;
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
      out8_reg <= 1'b0;
      out16_reg <= 1'b0;
      run8_reg <= 1'b0;
      run16_reg <= 1'b0;
      armed_reg <= 1'b0;
      status_reg <= 1'b0;
      cap_reg <= 16'h0000;
      irq8_reg <= 1'b0;
      irq16_reg <= 1'b0;
      en8_d_reg <= 1'b0;
      en16_d_reg <= 1'b0;
      sgl16_d_reg <= 1'b0;
      demod_d_reg <= 1'b0;
    end else begin
      pp_state_reg <= pp_state_next;
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      pin_s3_reg <= pin_s3_next;
      out8_reg <= out8_next;
      out16_reg <= out16_next;
      run8_reg <= run8_next;
      run16_reg <= run16_next;
      armed_reg <= armed_next;
      status_reg <= status_next;
      cap_reg <= cap_next;
      irq8_reg <= irq8_next;
      irq16_reg <= irq16_next;
      en8_d_reg <= en8_d_next;
      en16_d_reg <= en16_d_next;
      sgl16_d_reg <= sgl16_d_next;
      demod_d_reg <= demod_d_next;
    end
  end

  // ==========================================================
  // Counters
  dtp_down_counter #(.WIDTH(8)) u_timer8 (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(load8),
    .i_load_value(val8),
    .i_dec(run8_reg),
    .o_count(count8),
    .o_zero(zero8)
  );

  dtp_down_counter #(.WIDTH(16)) u_timer16 (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(load16),
    .i_load_value({i_timer16_high_hold, i_timer16_low_hold}),
    .i_dec(run16_reg),
    .o_count(count16),
    .o_zero(zero16)
  );

  assign o_timer8_output = out8_reg;
  assign o_timer16_output = out16_reg;
  assign o_timer16_capture = cap_reg;
  assign o_timer16_status = status_reg;
  assign o_timer8_irq = irq8_reg;
  assign o_timer16_irq = irq16_reg;

  // ==========================================================
  // Checks
  property p_ignore_edges;
    @(posedge i_clk) disable iff (!i_rstn)
    (demod && sgl16 && !armed_reg && edge_seen && run16_reg && en16 && !tc16)
      |=> (count16 == $past(count16) - 16'h0001);
  endproperty
  a_ignore_edges: assert property (p_ignore_edges) else $error("edge not ignored");

  property p_t8_capture;
    @(posedge i_clk) disable iff (!i_rstn)
    (demod && sgl16 && tc8 && !edge_load)
      |=> (o_timer16_capture == $past(count16)) && !$past(load16);
  endproperty
  a_t8_capture: assert property (p_t8_capture) else $error("timeout capture wrong");

  property p_rearm;
    @(posedge i_clk) disable iff (!i_rstn)
    (demod && sgl16 && !sgl16_d_reg && demod_d_reg) |=> armed_reg;
  endproperty
  a_rearm: assert property (p_rearm) else $error("capture not rearmed");

  property p_wrap;
    @(posedge i_clk) disable iff (!i_rstn)
    (demod && tc16 && !edge_load) |=> (count16 == dtp_pkg::WRAP_VALUE) && o_timer16_status;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer16 wrap missing");

  property p_demod_no_pp;
    @(posedge i_clk) disable iff (!i_rstn)
    demod |=> (pp_state_reg == dtp_pkg::PP_IDLE);
  endproperty
  a_demod_no_pp: assert property (p_demod_no_pp) else $error("ping-pong in demod");

  property p_pp_start;
    @(posedge i_clk) disable iff (!i_rstn)
    (!demod && pp_sel && pp_state_reg == dtp_pkg::PP_IDLE && rise8)
      |=> (o_timer8_output == $past(i_common_timer_control[dtp_pkg::INIT8_BIT])) && run8_reg;
  endproperty
  a_pp_start: assert property (p_pp_start) else $error("ping-pong start wrong");

  property p_pp_to16;
    @(posedge i_clk) disable iff (!i_rstn)
    (!demod && pp_sel && pp_state_reg == dtp_pkg::PP_T8 && tc8)
      |=> !run8_reg && run16_reg && (count16 == $past({i_timer16_high_hold, i_timer16_low_hold}));
  endproperty
  a_pp_to16: assert property (p_pp_to16) else $error("handover to timer16 wrong");

  property p_pp_to8;
    @(posedge i_clk) disable iff (!i_rstn)
    (!demod && pp_sel && pp_state_reg == dtp_pkg::PP_T16 && tc16)
      |=> run8_reg && !run16_reg && (pp_state_reg == dtp_pkg::PP_T8);
  endproperty
  a_pp_to8: assert property (p_pp_to8) else $error("handover to timer8 wrong");

  property p_irq_pulse;
    @(posedge i_clk) disable iff (!i_rstn)
    (!demod && tc8 && i_timer8_control[dtp_pkg::TC_IRQ_BIT]) |=> o_timer8_irq ##1 !o_timer8_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("timer8 interrupt not a pulse");

  property p_pp_end;
    @(posedge i_clk) disable iff (!i_rstn)
    (!demod && !pp_sel) |=> (pp_state_reg == dtp_pkg::PP_IDLE);
  endproperty
  a_pp_end: assert property (p_pp_end) else $error("ping-pong not ended");

endmodule

`default_nettype wire

// ==== dv/dtp_pin_model.sv ====
// Far-side pulse source that drives the demodulation input pin
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Pin driver
module dtp_pin_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_level,
  output logic o_pin
);
  // Pin moves just after the edge, like a source outside the chip
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin <= 1'h0;
    end else begin
      o_pin <= i_level;
    end
  end
endmodule

`default_nettype wire

// ==== dv/tb_dual_timer_demod_pingpong.sv ====
// Self-checking bench for the paired timers
`timescale 1ns/100ps
`default_nettype none

module tb_dual_timer_demod_pingpong;
  typedef struct {
    logic [7:0] rp;
    logic [3:0] grp;
    logic [3:0] bank;
    logic sel;
  } dtp_row_t;

  logic i_clk;
  logic i_rstn;
  logic [7:0] rp, c8, cc, c16, h8h, h8l, h16h, h16l;
  logic st_clr, pin_level, pin;
  logic [3:0] grp, bank;
  logic bsel, out8, out16, st, irq8, irq16;
  logic [15:0] cap, cap1;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  dtp_row_t rows [4] = '{'{8'h0d, 4'h0, 4'hd, 1'h1}, '{8'h7d, 4'h7, 4'hd, 1'h1},
                         '{8'h00, 4'h0, 4'h0, 1'h0}, '{8'hfc, 4'hf, 4'hc, 1'h0}};

  // ==========================================================
  // Design, far side and clock
  dtp_timer i_dtp_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_register_pointer(rp),
    .i_timer8_control(c8),
    .i_common_timer_control(cc),
    .i_timer16_control(c16),
    .i_timer8_high_hold(h8h),
    .i_timer8_low_hold(h8l),
    .i_timer16_high_hold(h16h),
    .i_timer16_low_hold(h16l),
    .i_timer16_status_clear(st_clr),
    .i_demod_pin(pin),
    .o_working_group(grp),
    .o_erf_bank(bank),
    .o_timer_bank_sel(bsel),
    .o_timer8_output(out8),
    .o_timer16_output(out16),
    .o_timer16_capture(cap),
    .o_timer16_status(st),
    .o_timer8_irq(irq8),
    .o_timer16_irq(irq16)
  );

  dtp_pin_model i_dtp_pin_model (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_level(pin_level),
    .o_pin(pin)
  );

  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Inputs move at least 1 ns after the edge so no race with the design
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      n_fail++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  // Sel 0 watches irq8, 1 irq16, 2 either; cnt 0 means none seen
  task automatic wait_irq(input int sel, input int lim, output int cnt);
    cnt = 0;
    for (int i = 1; i <= lim && cnt == 0; i++) begin
      step(1);
      if ((sel != 1 && irq8 === 1'h1) || (sel != 0 && irq16 === 1'h1)) begin
        cnt = i;
      end
    end
  endtask

  task automatic do_reset();
    i_rstn = 1'h0;
    c8 = 8'h00;
    cc = 8'h00;
    c16 = 8'h00;
    st_clr = 1'h0;
    pin_level = 1'h0;
    step(10);
    i_rstn = 1'h1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rp = 8'h0d;
    h8h = 8'h03;
    h8l = 8'h07;
    h16h = 8'h00;
    h16l = 8'h04;
    do_reset();
    check(out8 === 1'h0 && out16 === 1'h0 && st === 1'h0 && cap === 16'h0000, "reset values");
    foreach (rows[i]) begin
      rp = rows[i].rp;
      #1;
      check(grp === rows[i].grp && bank === rows[i].bank && bsel === rows[i].sel, "pointer");
    end
    cc = 8'h0f;
    c8 = 8'h42;
    c16 = 8'h42;
    step(1);
    c8 = 8'hc2;
    wait_irq(0, 10, n);
    check(n == 5 && out8 === 1'h1, "timer8 phase timing");
    check(out16 === 1'h1, "timer16 initial level");
    step(1);
    check(irq8 === 1'h0, "irq8 longer than one cycle");
    wait_irq(1, 10, n);
    check(n == 4, "timer16 phase timing");
    wait_irq(0, 10, n);
    check(n == 4 && out8 === 1'h1, "timer8 not re-enabled");
    c8 = 8'hc0;
    wait_irq(0, 12, n);
    check(n == 0, "masked irq8 raised");
    cc = 8'h03;
    step(20);
    wait_irq(2, 20, n);
    check(n == 0, "alternation did not stop");
    do_reset();
    cc = 8'h4f;
    c8 = 8'hc2;
    step(20);
    check(out16 === 1'h0, "alternation ran in demodulation");
    do_reset();
    h16l = 8'h40;
    h8l = 8'h05;
    cc = 8'h50;
    c16 = 8'hc6;
    step(2);
    check(st === 1'h0, "status set at demod start");
    // Edge capture raises no interrupt, so the captured count is checked
    pin_level = 1'h1;
    step(8);
    check(cap === 16'h003c, "first edge not captured");
    cap1 = cap;
    pin_level = 1'h0;
    step(4);
    pin_level = 1'h1;
    wait_irq(1, 8, n);
    check(n == 0 && cap === cap1, "later edge not ignored");
    c16 = 8'h86;
    step(1);
    c16 = 8'hc6;
    step(1);
    pin_level = 1'h0;
    step(4);
    pin_level = 1'h1;
    step(8);
    check(cap === 16'h0027, "rearmed edge not captured");
    c8 = 8'h80;
    wait_irq(1, 12, n);
    check(n == 7 && cap === 16'h0036, "timer8 timeout capture");
    for (int i = 0; i < 100 && st !== 1'h1; i++) begin
      step(1);
    end
    check(st === 1'h1, "wrap status not set");
    wait_irq(1, 8, n);
    check(n > 0 && cap[15:8] === 8'hff, "count not wrapped to all ones");
    st_clr = 1'h1;
    step(1);
    st_clr = 1'h0;
    step(1);
    check(st === 1'h0, "status not cleared");
    summarize();
  end

  // Whole run is near 220 cycles, so this only trips on a hang
  initial begin
    repeat (3000) @(posedge i_clk);
    n_fail++;
    summarize();
  end
endmodule

`default_nettype wire
